//--- inc/spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// ==========================================
// Register addresses
`define SPC_ADDR_CFG 8'h9A
`define SPC_ADDR_DAT 8'h9B
`define SPC_ADDR_CKR 8'h9D
`define SPC_ADDR_CTL 8'hF8
// ==========================================
// Reset values
`define SPC_CFG_RST 8'h07
`define SPC_CKR_RST 8'h00
`define SPC_CTL_RST 8'h00
// ==========================================
// Field positions
`define SPC_CFG_CPHA 7
`define SPC_CFG_CPOL 6
`define SPC_CFG_POS_LO 3
`define SPC_CFG_LEN_LO 0
`define SPC_CTL_BSY 3
`define SPC_CTL_SLV 2
// Writable bits of the configuration and control registers
`define SPC_CFG_WMASK 8'hC7
`define SPC_CTL_WMASK 8'hF3
// Slave word length less one
`define SPC_SLAVE_LEN_M1 3'h7
`endif

//--- inc/spc_pkg.sv
package spc_pkg;
  // ==========================================
  // Control and status bits
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
    logic transfer_in_progress;
    logic selected_as_slave;
    logic master_enable;
    logic port_enable;
  } spc_ctl_t;
  // ==========================================
  // Frame configuration bits
  typedef struct packed {
    logic clock_phase_sel;
    logic clock_idle_level;
    logic [2:0] bit_position_count;
    logic [2:0] frame_length_sel;
  } spc_cfg_t;
  // ==========================================
  // Sequencer states, Gray along idle-run-slave
  typedef enum logic [1:0] {
    SPC_IDLE = 2'b00,
    SPC_RUN = 2'b01,
    SPC_SLAVE = 2'b11
  } spc_state_t;
endpackage

//--- rtl/spc_port.sv
`timescale 1ns/1ps
`include "spc_cfg.svh"
// Behaviour
// - Four registers: control/status, data, configuration, clock rate.
// - Configuration bit 6 sets serial clock idle level.
// - Configuration bits 5:3 report the bit just shifted, read only.
// - Configuration bits 2:0 pick 1 to 8 master bits; slave ignores.
// - Master clock is system clock / (2 * (divisor + 1)).
// - Transfer done flag set when a master frame completes or slave selection ends, not on a master abort; software clears.
// - Data write during a transfer sets write collision flag.
// - Select low while master enabled sets mode fault flag.
// - Completed word with unread buffer sets receive overrun flag.
// - Busy bit reads one during a master transfer.
// - Slave-selected bit follows the select input while slave.
// - Control bit 1 chooses master or slave.
// - Control bit 0 enables the whole port.
// - Control register accepts single-bit writes.
// - Configuration bit 7 picks the latching clock edge.
// - Mode fault clears master and port enables.
// - Master data write starts an MSB-first transfer at once.
module spc_port
  import spc_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Byte write strobe
  input wire logic sfr_rd, // Read strobe
  input wire logic [7:0] sfr_wdata, // Write data
  output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
  input wire logic bit_wr, // Single-bit write to control register
  input wire logic [2:0] bit_idx, // Bit number for single-bit write
  input wire logic bit_val, // Value for single-bit write
  output logic irq_out, // Transfer done request, level
  input wire logic sck_in, // Serial clock pin input
  output logic sck_out, // Serial clock pin output
  output logic sck_oe_n, // Serial clock drive, low drives
  input wire logic mosi_in, // Master-out pin input
  output logic mosi_out, // Master-out pin output
  output logic mosi_oe_n, // Master-out drive, low drives
  input wire logic miso_in, // Master-in pin input
  output logic miso_out, // Master-in pin output
  output logic miso_oe_n, // Master-in drive, low drives
  input wire logic select_in_n // Slave select pin, active low
);
  // ==========================================
  // Pin synchronisers
  logic [1:0] sck_s_r;
  logic [1:0] mosi_s_r;
  logic [1:0] miso_s_r;
  logic [1:0] sel_s_r;
  logic sck_d_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sck_s_r <= 2'b00;
      mosi_s_r <= 2'b00;
      miso_s_r <= 2'b00;
      sel_s_r <= 2'b11;
      sck_d_r <= 1'b0;
    end else begin
      sck_s_r <= {sck_s_r[0], sck_in};
      mosi_s_r <= {mosi_s_r[0], mosi_in};
      miso_s_r <= {miso_s_r[0], miso_in};
      sel_s_r <= {sel_s_r[0], select_in_n};
      sck_d_r <= sck_s_r[1];
    end
  end
  // ==========================================
  // State
  spc_cfg_t cfg_r;
  spc_cfg_t cfg_nxt;
  spc_ctl_t ctl_r;
  spc_ctl_t ctl_nxt;
  spc_state_t state_r;
  spc_state_t state_nxt;
  logic [7:0] div_r;
  logic [7:0] tx_word_r;
  logic [7:0] tx_sr_r;
  logic [7:0] tx_sr_nxt;
  logic [7:0] rx_sr_r;
  logic [7:0] rx_sr_nxt;
  logic [7:0] rx_buf_r;
  logic rx_full_r;
  logic [3:0] edge_cnt_r;
  logic [3:0] edge_cnt_nxt;
  logic [2:0] samp_cnt_r;
  logic sck_r;
  logic sck_nxt;
  logic out_bit_r;
  logic out_bit_nxt;
  logic tick;
  // ==========================================
  // Decode
  wire wr_cfg = sfr_wr && (sfr_addr == `SPC_ADDR_CFG);
  wire wr_dat = sfr_wr && (sfr_addr == `SPC_ADDR_DAT);
  wire wr_ckr = sfr_wr && (sfr_addr == `SPC_ADDR_CKR);
  wire wr_ctl = sfr_wr && (sfr_addr == `SPC_ADDR_CTL);
  wire rd_dat = sfr_rd && (sfr_addr == `SPC_ADDR_DAT);
  wire bit_ok = bit_wr && (bit_idx != 3'(`SPC_CTL_BSY)) && (bit_idx != 3'(`SPC_CTL_SLV));
  wire sel_low = ~sel_s_r[1];
  wire port_on = ctl_r.port_enable;
  wire is_master = port_on && ctl_r.master_enable;
  wire slave_sel = port_on && !ctl_r.master_enable && sel_low;
  wire mode_fault = is_master && sel_low;
  wire cpha = cfg_r.clock_phase_sel;
  wire cpol = cfg_r.clock_idle_level;
  wire [2:0] len_m1 = is_master ? cfg_r.frame_length_sel : `SPC_SLAVE_LEN_M1;
  wire m_busy = (state_r == SPC_RUN);
  wire s_busy = (state_r == SPC_SLAVE);
  wire m_start = wr_dat && is_master && !mode_fault && (state_r == SPC_IDLE);
  wire s_start = slave_sel && (state_r == SPC_IDLE);
  wire write_collision_flag_ev = wr_dat && (m_busy || s_busy);
  // ==========================================
  // Edge events
  wire m_edge = m_busy && tick && !mode_fault;
  wire m_last = m_edge && (edge_cnt_r == {len_m1, 1'b1});
  wire m_sample = m_edge && (edge_cnt_r[0] == cpha);
  wire m_launch = m_edge && (edge_cnt_r[0] != cpha) && !m_last;
  wire s_edge = s_busy && slave_sel && (sck_s_r[1] != sck_d_r);
  wire s_lead = (sck_s_r[1] != cpol);
  wire s_sample = s_edge && (s_lead != cpha);
  wire s_launch = s_edge && (s_lead == cpha);
  wire s_end = s_busy && !slave_sel;
  wire sample = m_sample || s_sample;
  wire launch = m_launch || s_launch;
  wire sample_in = is_master ? miso_s_r[1] : mosi_s_r[1];
  wire finish = m_last || s_end;
  wire [7:0] rx_shift = {rx_sr_r[6:0], sample_in};
  wire [7:0] rx_word = sample ? rx_shift : rx_sr_r;
  wire overrun = finish && rx_full_r;
  wire commit = finish && !rx_full_r;
  wire load_first = m_start ? !cpha : (s_start && !cpha);
  wire [7:0] load_word = m_start ? sfr_wdata : tx_word_r;
  // ==========================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SPC_IDLE: begin
        if (m_start) begin
          state_nxt = SPC_RUN;
        end else if (s_start) begin
          state_nxt = SPC_SLAVE;
        end
      end
      SPC_RUN: begin
        if (m_last || mode_fault || !is_master) begin
          state_nxt = SPC_IDLE;
        end
      end
      SPC_SLAVE: begin
        if (s_end) begin
          state_nxt = SPC_IDLE;
        end
      end
      default: state_nxt = SPC_IDLE;
    endcase
  end
  // ==========================================
  // Shift path, MSB first
  always_comb begin
    tx_sr_nxt = tx_sr_r;
    out_bit_nxt = out_bit_r;
    rx_sr_nxt = rx_sr_r;
    edge_cnt_nxt = edge_cnt_r;
    if (m_start || s_start) begin
      tx_sr_nxt = load_word;
      rx_sr_nxt = 8'h00;
      edge_cnt_nxt = 4'h0;
      if (load_first) begin
        out_bit_nxt = load_word[len_m1];
        tx_sr_nxt = {load_word[6:0], 1'b0};
      end
    end else begin
      if (launch) begin
        out_bit_nxt = tx_sr_r[len_m1];
        tx_sr_nxt = {tx_sr_r[6:0], 1'b0};
      end
      if (sample) begin
        rx_sr_nxt = rx_shift;
      end
      if (m_edge) begin
        edge_cnt_nxt = 4'(edge_cnt_r + 4'h1);
      end
    end
  end
  // Master clock level
  always_comb begin
    sck_nxt = sck_r;
    if (m_edge && state_nxt == SPC_RUN) begin
      sck_nxt = ~sck_r;
    end else if (state_nxt != SPC_RUN) begin
      sck_nxt = cpol;
    end
  end
  // ==========================================
  // Configuration register
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = spc_cfg_t'((sfr_wdata & `SPC_CFG_WMASK) | (8'(cfg_r) & ~`SPC_CFG_WMASK));
    end
    if (m_start || s_start) begin
      cfg_nxt.bit_position_count = 3'h0;
    end else if (sample) begin
      cfg_nxt.bit_position_count = 3'(len_m1 - samp_cnt_r);
    end
  end
  // ==========================================
  // Control and status register
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = spc_ctl_t'((sfr_wdata & `SPC_CTL_WMASK) | (8'(ctl_r) & ~`SPC_CTL_WMASK));
    end
    if (bit_ok) begin
      ctl_nxt[bit_idx] = bit_val;
    end
    if (finish) begin
      ctl_nxt.transfer_done_flag = 1'b1;
    end
    if (write_collision_flag_ev) begin
      ctl_nxt.write_collision_flag = 1'b1;
    end
    if (mode_fault) begin
      ctl_nxt.mode_fault_flag = 1'b1;
      ctl_nxt.master_enable = 1'b0;
      ctl_nxt.port_enable = 1'b0;
    end
    if (overrun) begin
      ctl_nxt.receive_overrun_flag = 1'b1;
    end
    ctl_nxt.transfer_in_progress = (state_nxt == SPC_RUN);
    ctl_nxt.selected_as_slave = slave_sel;
  end
  // ==========================================
  // Register file
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_r <= spc_cfg_t'(`SPC_CFG_RST);
      ctl_r <= spc_ctl_t'(`SPC_CTL_RST);
      div_r <= `SPC_CKR_RST;
      tx_word_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      if (wr_ckr) begin
        div_r <= sfr_wdata;
      end
      if (wr_dat && !write_collision_flag_ev) begin
        tx_word_r <= sfr_wdata;
      end
    end
  end
  // Shift and receive buffer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= SPC_IDLE;
      tx_sr_r <= 8'h00;
      rx_sr_r <= 8'h00;
      rx_buf_r <= 8'h00;
      rx_full_r <= 1'b0;
      edge_cnt_r <= 4'h0;
      samp_cnt_r <= 3'h0;
      out_bit_r <= 1'b0;
      sck_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tx_sr_r <= tx_sr_nxt;
      rx_sr_r <= rx_sr_nxt;
      out_bit_r <= out_bit_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      sck_r <= sck_nxt;
      if (m_start || s_start) begin
        samp_cnt_r <= 3'h0;
      end else if (sample) begin
        samp_cnt_r <= 3'(samp_cnt_r + 3'h1);
      end
      if (commit) begin
        rx_buf_r <= rx_word;
      end
      rx_full_r <= commit || (rx_full_r && !rd_dat);
    end
  end
  // ==========================================
  // Read port
  wire [7:0] rd_mux = (sfr_addr == `SPC_ADDR_CFG) ? 8'(cfg_r) :
                      (sfr_addr == `SPC_ADDR_DAT) ? rx_buf_r :
                      (sfr_addr == `SPC_ADDR_CKR) ? div_r :
                      (sfr_addr == `SPC_ADDR_CTL) ? 8'(ctl_r) : 8'h00;
  // ==========================================
  // Output flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      irq_out <= 1'b0;
      sck_out <= 1'b0;
      sck_oe_n <= 1'b1;
      mosi_out <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      if (sfr_rd) begin
        sfr_rdata <= rd_mux;
      end
      irq_out <= ctl_nxt.transfer_done_flag;
      sck_out <= sck_nxt;
      sck_oe_n <= !(ctl_nxt.port_enable && ctl_nxt.master_enable);
      mosi_out <= out_bit_nxt;
      mosi_oe_n <= !(ctl_nxt.port_enable && ctl_nxt.master_enable);
      miso_out <= out_bit_nxt;
      miso_oe_n <= !ctl_nxt.selected_as_slave;
    end
  end
  // ==========================================
  // Half-period divider
  spc_sck_gen u_sck_gen (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(m_busy),
    .divisor(div_r),
    .tick(tick)
  );
endmodule // spc_port

//--- rtl/spc_sck_gen.sv
`timescale 1ns/1ps
`include "spc_cfg.svh"
module spc_sck_gen (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic run, // Count while high
  input wire logic [7:0] divisor, // Half period less one
  output logic tick // One-cycle half-period pulse
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_nxt;
  wire at_end = (cnt_r == divisor);
  assign tick_nxt = run && at_end;
  assign cnt_nxt = (!run || at_end) ? 8'h00 : 8'(cnt_r + 8'h01);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule // spc_sck_gen

//--- test/spc_port_chk.sv
`timescale 1ns/1ps
`include "spc_cfg.svh"
module spc_port_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] sfr_addr, // Address
  input wire logic sfr_wr, // Write
  input wire logic sfr_rd, // Read
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic bit_wr, // Bit write
  input wire logic [2:0] bit_idx, // Bit number
  input wire logic bit_val, // Bit value
  input wire logic irq_out, // Done level
  input wire logic sck_oe_n, // Clock drive
  input wire logic mosi_oe_n, // Out drive
  input wire logic miso_oe_n, // In drive
  input wire logic select_in_n // Select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire ctl_wr = sfr_wr && sfr_addr == `SPC_ADDR_CTL;
  wire top_bw = bit_wr && bit_idx == 3'h7;
  // ==========================================
  // Port checks
  a_reset_outputs: assert property ($rose(rst_n) |-> !irq_out && sck_oe_n && mosi_oe_n && miso_oe_n)
    else $error("outputs not at reset level");
  a_miso_release: assert property (select_in_n [*5] |-> miso_oe_n)
    else $error("miso driven while unselected");
  a_done_sticky: assert property (irq_out && !ctl_wr && !top_bw |=> irq_out)
    else $error("done flag dropped by hardware");
  a_done_sw_set: assert property ((ctl_wr && sfr_wdata[7] && !top_bw) || (top_bw && bit_val) |=> irq_out)
    else $error("done flag not set by write");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  a_rd_unmapped: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_slave_no_sck: assert property (!miso_oe_n |-> sck_oe_n)
    else $error("slave drives clock");
  a_slave_no_mosi: assert property (!miso_oe_n |-> mosi_oe_n)
    else $error("slave drives master data line");
  a_fault_release: assert property (!select_in_n [*4] |-> sck_oe_n && mosi_oe_n)
    else $error("master drives while select low");
endmodule // spc_port_chk
bind spc_port spc_port_chk u_chk (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .bit_wr, .bit_idx, .bit_val, .irq_out, .sck_oe_n, .mosi_oe_n, .miso_oe_n, .select_in_n);

//--- test/spc_spi_slave.sv
`timescale 1ns/1ps
module spc_spi_slave (
  input wire logic sck, // Serial clock
  input wire logic mosi, // From master
  input wire logic cs_n, // Select
  input wire logic cpol, // Idle level
  input wire logic cpha, // Phase
  input wire logic [7:0] tx, // Word to send
  output logic miso, // To master
  output logic [7:0] rx // Word received
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  always @(negedge cs_n) begin
    sh = tx;
    rx = 8'h00;
    if (!cpha) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
  // Released line shows the inverse
  always @(posedge cs_n) miso = ~miso;
  always @(sck) begin
    if (!cs_n && ((sck != cpol) ^ cpha)) begin
      rx = {rx[6:0], mosi};
    end else if (!cs_n) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule // spc_spi_slave

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "spc_cfg.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  logic ref_clk, rst_n, sfr_wr, sfr_rd, bit_wr, bit_val, s_sck, s_mosi, sel_n, cs_n, cpol, cpha;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, tx, prx;
  logic [2:0] bit_idx;
  logic irq_out, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso, miso_out, miso_oe_n;
  int fails = 0;
  int checks_done = 0;
  spc_port DUT (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_wr, .bit_idx,
    .bit_val, .irq_out, .sck_in(s_sck), .sck_out, .sck_oe_n, .mosi_in(s_mosi), .mosi_out, .mosi_oe_n,
    .miso_in(miso), .miso_out, .miso_oe_n, .select_in_n(sel_n));
  spc_spi_slave PEER (.sck(sck_out), .mosi(mosi_out), .cs_n, .cpol, .cpha, .tx, .miso, .rx(prx));
  task automatic put(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    bit_idx = a[2:0];
    bit_val = d[0];
    {bit_wr, sfr_wr} = {b, !b};
    @(posedge ref_clk);
    #1;
    {bit_wr, sfr_wr} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(n, e, sfr_rdata)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #(60000 * 25);
    fails++;
    end_of_test;
  end
  initial begin : main
    int n, ck, tg, gap, k, buf_v, unread, ctl_e;
    logic last;
    logic [7:0] d, s;
    {rst_n, sfr_wr, sfr_rd, bit_wr, bit_val, s_sck, s_mosi, cpol, cpha} = '0;
    {sel_n, cs_n, sfr_addr, sfr_wdata, bit_idx, tx} = {2'b11, 27'h0};
    void'($urandom(32'h5f7a_00ba));
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    rd(`SPC_ADDR_CFG, `SPC_CFG_RST, "cfg reset");
    rd(`SPC_ADDR_CKR, `SPC_CKR_RST, "ckr reset");
    rd(`SPC_ADDR_CTL, `SPC_CTL_RST, "ctl reset");
    rd(8'h00, 8'h00, "unmapped");
    // ==========================================
    // Master frames over all modes
    unread = 0;
    for (int i = 0; i < 8; i++) begin
      {cpha, cpol} = i[1:0];
      n = (i == 0) ? 7 : $urandom_range(7);
      ck = (i == 0) ? 255 : $urandom_range(5, 2);
      d = $urandom;
      tx = $urandom;
      put(1'b0, `SPC_ADDR_CTL, 8'h00);
      put(1'b0, `SPC_ADDR_CFG, {cpha, cpol, 3'b000, n[2:0]});
      put(1'b0, `SPC_ADDR_CKR, ck[7:0]);
      put(1'b0, `SPC_ADDR_CTL, 8'h03);
      cs_n = 1'b0;
      put(1'b0, `SPC_ADDR_DAT, d);
      sfr_wdata = ~d;
      {tg, gap, last} = {32'd0, 32'd0, cpol};
      for (k = 0; k < 5000 && irq_out !== 1'b1; k++) begin
        @(posedge ref_clk);
        #1;
        sfr_wr = (i == 3 && k == 4);
        gap++;
        if (sck_out !== last) begin
          if (tg > 0) `CHK("half period", ck + 1, gap)
          tg++;
          gap = 0;
        end
        last = sck_out;
      end
      cs_n = 1'b1;
      `CHK("irq", 1'b1, irq_out)
      `CHK("toggles", 2 * n + 2, tg)
      `CHK("sck idle", cpol, sck_out)
      `CHK("peer rx", d & 8'(255 >> (7 - n)), prx)
      ctl_e = 8'h83 | (unread ? 8'h10 : 0) | (i == 3 ? 8'h40 : 0);
      if (!unread) buf_v = tx >> (7 - n);
      unread = 1;
      rd(`SPC_ADDR_CTL, ctl_e[7:0], "ctl done");
      rd(`SPC_ADDR_CFG, {cpha, cpol, 3'b000, n[2:0]}, "bit count");
      if (i % 3 != 1) begin
        rd(`SPC_ADDR_DAT, buf_v[7:0], "rx data");
        unread = 0;
      end
    end
    rd(`SPC_ADDR_DAT, buf_v[7:0], "rx held");
    // ==========================================
    // Single-bit access and mode fault
    put(1'b0, `SPC_ADDR_CTL, 8'h00);
    put(1'b1, 8'h07, 8'h01);
    put(1'b1, 8'h03, 8'h01);
    put(1'b1, 8'h00, 8'h01);
    rd(`SPC_ADDR_CTL, 8'h81, "bit set");
    put(1'b1, 8'h07, 8'h00);
    rd(`SPC_ADDR_CTL, 8'h01, "bit clear");
    put(1'b0, `SPC_ADDR_CTL, 8'h03);
    put(1'b0, `SPC_ADDR_CKR, 8'hFF);
    put(1'b0, `SPC_ADDR_DAT, 8'h5A);
    rd(`SPC_ADDR_CTL, 8'h0B, "busy");
    sel_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    sel_n = 1'b1;
    rd(`SPC_ADDR_CTL, 8'h20, "mode fault");
    `CHK("abort irq", 1'b0, irq_out)
    // ==========================================
    // Slave frame, frame size ignored
    put(1'b0, `SPC_ADDR_CFG, 8'h00);
    put(1'b0, `SPC_ADDR_CTL, 8'h01);
    put(1'b0, `SPC_ADDR_DAT, tx);
    d = $urandom;
    sel_n = 1'b0;
    for (int b = 7; b >= 0; b--) begin
      s_mosi = d[b];
      repeat (12) @(posedge ref_clk);
      #1;
      s[b] = miso_out;
      `CHK("miso drive", 1'b0, miso_oe_n)
      s_sck = 1'b1;
      repeat (12) @(posedge ref_clk);
      #1;
      s_sck = 1'b0;
    end
    put(1'b0, `SPC_ADDR_DAT, ~tx);
    rd(`SPC_ADDR_CTL, 8'h45, "selected");
    `CHK("miso word", tx, s)
    sel_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`SPC_ADDR_CTL, 8'hC1, "slave done");
    rd(`SPC_ADDR_DAT, d, "slave rx");
    end_of_test;
  end
endmodule // tb_top
